// *** verilog/ecm_pkg.sv ***
// package: constants, register map and types of the encoder fieldbus map
// assumes: included first in compile order by every design file
package ecm_pkg;

   localparam int MAG_MAX = 11;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] REG_PRM = 8'h00;
   localparam logic [7:0] REG_RANGE = 8'h04;
   localparam logic [7:0] REG_PRESET = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0C;
   localparam logic [7:0] REG_CMD = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_IRQ_STAT = 8'h18;
   localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
   localparam logic [7:0] REG_ID = 8'h20;

   // parameter byte bits
   localparam int PRM_CODE_SEQ_BIT = 0;
   localparam int PRM_CLASS2_BIT = 1;
   localparam int PRM_SCALE_BIT = 3;
   localparam logic [7:0] PRM_RST = 8'h00;
   localparam logic [7:0] PRM_MASK = 8'h0B;
   localparam logic [31:0] RANGE_RST = 32'h000186A0;
   localparam logic [31:0] PRESET_RST = 32'h00000000;

   // configuration register fields
   localparam int CFG_SEL_LSB = 0;
   localparam int CFG_M16_LSB = 4;
   localparam int CFG_M32_LSB = 8;

   // command register bits
   localparam int CMD_PRM_BIT = 0;
   localparam int CMD_CFG_BIT = 1;
   localparam int CMD_LEAVE_BIT = 2;

   // status register fields
   localparam int STS_ST_LSB = 0;
   localparam int STS_ERR_BIT = 2;
   localparam int STS_BUSY_BIT = 3;
   localparam int STS_IN_LSB = 8;
   localparam int STS_OUT_LSB = 16;
   localparam int STS_DIAG_LSB = 24;
   localparam logic [7:0] DIAG_LEN_C1_32 = 8'h10;

   // interrupt bits
   localparam int IRQ_W = 5;
   localparam int IRQ_PRM = 0;
   localparam int IRQ_CFG_OK = 1;
   localparam int IRQ_CFG_ERR = 2;
   localparam int IRQ_PRESET = 3;
   localparam int IRQ_CYCLE = 4;

   // identity value, arbitrary
   localparam logic [31:0] ID_VALUE = 32'h00E1C0DE;

   typedef enum logic [2:0] {
      ECM_C1_16 = 3'h0,
      ECM_C1_32 = 3'h1,
      ECM_C2_16 = 3'h2,
      ECM_C2_32 = 3'h3,
      ECM_EXT_32 = 3'h4
   } ecm_cfg_t;

   typedef enum logic [1:0] {
      ECM_WAIT_PRM = 2'h0,
      ECM_WAIT_CFG = 2'h1,
      ECM_EXCH = 2'h3
   } ecm_state_t;

endpackage : ecm_pkg

// *** verilog/ecm_word_if.sv ***
// interface: one position word handed from the map to the byte serialiser
// assumes: both ends on clk_i
`timescale 1ns/1ns
interface ecm_word_if;
   logic [31:0] word;
   logic wide;
   logic valid;
   logic ready;
   modport src (output word, output wide, output valid, input ready);
   modport snk (input word, input wide, input valid, output ready);
endinterface : ecm_word_if

// *** verilog/ecm_word_ser.sv ***
// module: splits a 16- or 32-bit word into bytes, most significant first
// assumes: clk_i free running, rst_i synchronous active high
`timescale 1ns/1ns
module ecm_word_ser (
   input wire logic clk_i,
   input wire logic rst_i,
   ecm_word_if.snk w,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i
);
   import ecm_pkg::*;

   typedef struct packed {
      logic [31:0] shift;
      logic [2:0] left;
   } ecm_ser_t;

   ecm_ser_t q, d;

   assign w.ready = (q.left == 3'h0);
   assign tx_valid_o = (q.left != 3'h0);
   assign tx_data_o = q.shift[31:24];

   always_comb begin
      d = q;
      if (w.valid && w.ready) begin
         d.shift = w.wide ? w.word : {w.word[15:0], 16'h0000};
         d.left = w.wide ? 3'h4 : 3'h2;
      end else if (tx_valid_o && tx_ready_i) begin
         d.shift = {q.shift[23:0], 8'h00};
         d.left = q.left - 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule : ecm_word_ser

// *** verilog/ecm_map.sv ***
// module: fieldbus slave parameter, configuration and process-data map
// assumes: wishbone classic master on clk_i; fieldbus byte engine outside
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ns
module ecm_map #(
   parameter int MAG_N = ecm_pkg::MAG_MAX
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic [31:0] position_i,
   input wire logic [MAG_N*32-1:0] magnet_pos_i,
   input wire logic cycle_start_i,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic ext_preset_i,
   output logic preset_o,
   output logic [31:0] preset_value_o,
   output logic scale_en_o,
   output logic exch_o
);
   import ecm_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] prm;
      logic [31:0] range;
      logic [31:0] preset_val;
      ecm_cfg_t cfg;
      logic [3:0] m16;
      logic [3:0] m32;
      ecm_state_t st;
      logic cfg_err;
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] mask;
      logic sending;
      logic [3:0] item;
      logic [31:0] rx_buf;
      logic [2:0] rx_cnt;
      logic preset;
      logic [31:0] preset_out;
      logic ext_seen;
   } ecm_map_t;

   ecm_map_t q, d;
   ecm_word_if wif ();

   logic wr;
   logic [31:0] wmask;
   logic [31:0] cfg_word;
   logic [31:0] sts_word;
   logic [7:0] in_words;
   logic [7:0] out_words;
   logic [2:0] out_bytes;
   logic prim_wide;
   logic class2;
   logic [3:0] items;
   logic [IRQ_W-1:0] ev;
   logic [31:0] mag_raw;
   logic [31:0] raw;
   logic [3:0] mag_sel;
   logic [4:0] mag_tot;
   logic [31:0] rx_word;

   ////////////////////////////////////////////////////////////////////
   // byte enables and decoded configuration
   always_comb begin
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      // write lands on the ack edge only, matching when the master releases
      wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
      cfg_word = 32'h0;
      cfg_word[CFG_SEL_LSB +: 3] = q.cfg;
      cfg_word[CFG_M16_LSB +: 4] = q.m16;
      cfg_word[CFG_M32_LSB +: 4] = q.m32;
      prim_wide = (q.cfg != ECM_C1_16) && (q.cfg != ECM_C2_16);
      class2 = (q.cfg == ECM_C2_16) || (q.cfg == ECM_C2_32) || (q.cfg == ECM_EXT_32);
      // word counts follow the last written configuration, accepted or rejected
      in_words = 8'(prim_wide ? 2 : 1) + 8'(q.m16) + 8'({q.m32, 1'b0});
      out_words = !class2 ? 8'h00 : (prim_wide ? 8'h02 : 8'h01);
      out_bytes = 3'({out_words[1:0], 1'b0});
      // items per cycle: primary word plus every magnet module
      items = 4'h1 + q.m16 + q.m32;
      sts_word = 32'h0;
      sts_word[STS_ST_LSB +: 2] = q.st;
      sts_word[STS_ERR_BIT] = q.cfg_err;
      // busy until the last byte has left, not only the last word
      sts_word[STS_BUSY_BIT] = q.sending || tx_valid_o;
      sts_word[STS_IN_LSB +: 8] = in_words;
      sts_word[STS_OUT_LSB +: 8] = out_words;
      // diagnosis length offered only in class 1 32-bit
      sts_word[STS_DIAG_LSB +: 8] = (q.cfg == ECM_C1_32) ? DIAG_LEN_C1_32 : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////
   // word selection for the serialiser
   always_comb begin
      // one shared mux for all magnets, slots beyond MAG_N read as zero
      mag_sel = (q.item == 4'h0) ? 4'h0 : q.item - 4'h1;
      mag_raw = 32'h0;
      for (int i = 0; i < MAG_N; i++) begin
         if (mag_sel == 4'(i)) begin
            mag_raw = magnet_pos_i[i*32 +: 32];
         end
      end
      // class 1 16-bit: raw base resolution, no scaling
      raw = (q.item == 4'h0) ? position_i : mag_raw;
      // reversed count direction measured against the range
      wif.word = q.prm[PRM_CODE_SEQ_BIT] ? q.range - raw : raw;
      // magnet words are 16-bit or 32-bit by module type
      wif.wide = (q.item == 4'h0) ? prim_wide : (q.m32 != 4'h0);
      wif.valid = q.sending;
   end

   ecm_word_ser u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .w(wif.snk),
      .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i)
   );

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      ev = '0;
      d.preset = 1'b0;
      mag_tot = 5'(q.m16) + 5'(q.m32);
      rx_word = {q.rx_buf[23:0], rx_data_i};
      // one wait state: registered ack, read data captured at the take edge
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         case (wb_adr_i)
            REG_PRM: d.rdat = {24'h0, q.prm};
            REG_RANGE: d.rdat = q.range;
            REG_PRESET: d.rdat = q.preset_val;
            REG_CFG: d.rdat = cfg_word;
            REG_STATUS: d.rdat = sts_word;
            REG_IRQ_STAT: d.rdat = 32'(q.stat);
            REG_IRQ_MASK: d.rdat = 32'(q.mask);
            REG_ID: d.rdat = ID_VALUE;
            default: d.rdat = 32'h0;
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            REG_PRM: begin
               if (wb_sel_i[0] && q.st == ECM_WAIT_PRM) begin
                  d.prm = wb_dat_i[7:0] & PRM_MASK;
               end
            end
            REG_RANGE: begin
               d.range = (q.range & ~wmask) | (wb_dat_i & wmask);
            end
            REG_PRESET: begin
               d.preset_val = (q.preset_val & ~wmask) | (wb_dat_i & wmask);
            end
            REG_CFG: begin
               if (q.st != ECM_EXCH && wb_sel_i[0] && wb_sel_i[1]) begin
                  d.cfg = ecm_cfg_t'(wb_dat_i[CFG_SEL_LSB +: 3]);
                  d.m16 = wb_dat_i[CFG_M16_LSB +: 4];
                  d.m32 = wb_dat_i[CFG_M32_LSB +: 4];
               end
            end
            REG_CMD: begin
               if (wb_sel_i[0]) begin
                  if (wb_dat_i[CMD_PRM_BIT] && q.st == ECM_WAIT_PRM) begin
                     d.st = ECM_WAIT_CFG;
                     ev[IRQ_PRM] = 1'b1;
                  end
                  if (wb_dat_i[CMD_CFG_BIT] && q.st == ECM_WAIT_CFG) begin
                     // reject mixed widths, excess magnets, unknown configs
                     // single nominal configuration plus at most eleven magnets
                     if ((q.m16 != 4'h0 && q.m32 != 4'h0) || mag_tot > 5'(MAG_N)
                         || q.cfg > ECM_EXT_32) begin
                        d.cfg_err = 1'b1;
                        ev[IRQ_CFG_ERR] = 1'b1;
                     end else begin
                        d.cfg_err = 1'b0;
                        d.st = ECM_EXCH;
                        ev[IRQ_CFG_OK] = 1'b1;
                     end
                  end
                  // leave wins over accept in one write, so the host can always recover
                  if (wb_dat_i[CMD_LEAVE_BIT]) begin
                     d.st = ECM_WAIT_PRM;
                     d.sending = 1'b0;
                     d.rx_cnt = 3'h0;
                  end
               end
            end
            REG_IRQ_MASK: begin
               if (wb_sel_i[0]) begin
                  d.mask = wb_dat_i[IRQ_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      // input data cycle: primary word then magnets
      if (q.st == ECM_EXCH && !q.sending && cycle_start_i) begin
         d.sending = 1'b1;
         d.item = 4'h0;
      end else if (q.sending && wif.ready) begin
         if (q.item == items - 4'h1) begin
            d.sending = 1'b0;
            ev[IRQ_CYCLE] = 1'b1;
         end else begin
            d.item = q.item + 4'h1;
         end
      end
      // output word from the master, high byte first
      // class 1 has no output data, stray bytes are dropped
      if (q.st == ECM_EXCH && class2 && rx_valid_i) begin
         d.rx_buf = rx_word;
         if (q.rx_cnt == out_bytes - 3'h1) begin
            d.rx_cnt = 3'h0;
            // top bit of the output data commands a preset
            if (prim_wide && rx_word[31] && q.prm[PRM_CLASS2_BIT]) begin
               d.preset = 1'b1;
               d.preset_out = {1'b0, rx_word[30:0]};
            end else if (!prim_wide && rx_word[15] && q.prm[PRM_CLASS2_BIT]) begin
               d.preset = 1'b1;
               d.preset_out = {17'h0, rx_word[14:0]};
            end
         end else begin
            d.rx_cnt = q.rx_cnt + 3'h1;
         end
      end
      // external preset loads the preset value parameter
      // a held preset pin fires once, on its rising edge only
      d.ext_seen = ext_preset_i;
      if (q.st == ECM_EXCH && q.cfg == ECM_EXT_32 && ext_preset_i && !q.ext_seen
          && !d.preset) begin
         d.preset = 1'b1;
         d.preset_out = q.preset_val;
      end
      ev[IRQ_PRESET] = d.preset;
      // an event in the clearing cycle survives
      if (wr && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) begin
         d.stat = (q.stat & ~wb_dat_i[IRQ_W-1:0]) | ev;
      end else begin
         d.stat = q.stat | ev;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.prm <= PRM_RST;
         q.range <= RANGE_RST;
         q.preset_val <= PRESET_RST;
         q.cfg <= ECM_C1_16;
         q.st <= ECM_WAIT_PRM;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   // level interrupt straight from the sticky bits
   assign irq_o = |(q.stat & q.mask);
   assign preset_o = q.preset;
   assign preset_value_o = q.preset_out;
   // scaling only where the configuration allows it
   assign scale_en_o = class2 && q.prm[PRM_SCALE_BIT] && q.st == ECM_EXCH;
   assign exch_o = (q.st == ECM_EXCH);

endmodule : ecm_map

// *** tb/ecm_map_monitor.sv ***
// checker: port relations of the encoder fieldbus map
// assumes: bound to ecm_map, one clock, synchronous reset
`timescale 1ns/1ns
module ecm_map_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic preset_o,
   input wire logic [31:0] preset_value_o,
   input wire logic exch_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("ack late");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   // reset itself must clear these, so no disable here
   property p_rst; disable iff (1'b0) rst_i |=> !exch_o && !tx_valid_o && !irq_o; endproperty
   a_rst: assert property (p_rst)
      else $error("outputs active after reset");
   property p_tx_exch; $rose(tx_valid_o) |-> exch_o; endproperty
   a_tx_exch: assert property (p_tx_exch)
      else $error("input data outside exchange");
   property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("byte lost while stalled");
   property p_preset_once; preset_o |=> !preset_o; endproperty
   a_preset_once: assert property (p_preset_once)
      else $error("preset pulse too long");
   property p_preset_val; $changed(preset_value_o) |-> preset_o; endproperty
   a_preset_val: assert property (p_preset_val)
      else $error("preset value moved without pulse");
   c_exch: cover property ($rose(exch_o));
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_preset: cover property (preset_o);
endmodule : ecm_map_monitor

bind ecm_map ecm_map_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .preset_o(preset_o), .preset_value_o(preset_value_o),
   .exch_o(exch_o), .irq_o(irq_o));

// *** tb/ecm_far_model.sv ***
// model: bus master side of the process-data byte streams
// assumes: bench reads got and calls send_word; slow_i halves ready rate
`timescale 1ns/1ns
module ecm_far_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   logic [7:0] got[$];
   initial begin
      tx_ready_o = 1'b0;
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
   end
   task automatic send_word(input logic [31:0] w);
      for (int i = 3; i >= 0; i--) begin
         @(posedge clk_i);
         rx_data_o <= w[i*8+:8];
         rx_valid_o <= 1'b1;
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      // released line must not keep the last byte
      rx_data_o <= ~w[7:0];
   endtask : send_word
endmodule : ecm_far_model

// *** tb/ecm_map_tb.sv ***
// bench: register and process-data tests of the encoder fieldbus map
// assumes: wishbone classic master here, far model on the byte streams
`timescale 1ns/1ns
module ecm_map_tb;
   import ecm_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cycle_start_i, ext_preset_i, slow;
   logic [7:0] wb_adr_i, tx_data_o, rx_data_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, position_i, rd, preset_value_o;
   logic [351:0] magnet_pos_i;
   logic wb_ack_o, irq_o, tx_valid_o, tx_ready_i, rx_valid_i, preset_o, scale_en_o, exch_o;
   int num_errors = 0;
   int checks = 0;
   ecm_map u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .position_i(position_i),
      .magnet_pos_i(magnet_pos_i), .cycle_start_i(cycle_start_i), .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i),
      .rx_valid_i(rx_valid_i), .ext_preset_i(ext_preset_i), .preset_o(preset_o),
      .preset_value_o(preset_value_o), .scale_en_o(scale_en_o), .exch_o(exch_o));
   ecm_far_model u_far (.clk_i(clk_i), .slow_i(slow), .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
      .rx_valid_o(rx_valid_i));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic finish_test;
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("wb_ack_cycles", 32'h2, 32'(n));
   endtask : wb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input string what);
      wb(1'b0, a, 32'h0);
      chk(what, e, rd & m);
   endtask : rdchk
   task automatic setup(input logic [31:0] prm, input logic [31:0] cfg);
      wb(1'b1, REG_CMD, 32'h4);
      wb(1'b1, REG_PRM, prm);
      wb(1'b1, REG_CMD, 32'h1);
      wb(1'b1, REG_CFG, cfg);
      wb(1'b1, REG_CMD, 32'h2);
   endtask : setup
   task automatic run_cycle(input int nb, input logic [63:0] e);
      int n;
      n = 0;
      u_far.got.delete();
      @(posedge clk_i);
      cycle_start_i <= 1'b1;
      @(posedge clk_i);
      cycle_start_i <= 1'b0;
      while (u_far.got.size() < nb && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk("byte_count", nb, 32'(u_far.got.size()));
      for (int i = 0; i < nb; i++) chk("tx_byte", 32'(e[(nb-1-i)*8+:8]), 32'(u_far.got[i]));
   endtask : run_cycle
   task automatic wait_preset(input logic [31:0] e);
      int n;
      n = 0;
      while (preset_o !== 1'b1 && n < 30) begin
         @(posedge clk_i);
         n++;
      end
      chk("preset_o", 32'h1, 32'(preset_o));
      chk("preset_value", e, preset_value_o);
   endtask : wait_preset
   initial begin
      {rst_i, slow} = 2'b10;
      {wb_cyc_i, wb_stb_i, wb_we_i, cycle_start_i, ext_preset_i} = 5'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hF};
      position_i = 32'h1234ABCD;
      magnet_pos_i = {288'h0, 64'h00007788_00005566};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(REG_PRM, 32'hFF, 32'h0, "prm");
      rdchk(REG_RANGE, '1, 32'h000186A0, "range");
      rdchk(REG_ID, '1, ID_VALUE, "id");
      rdchk(8'h3C, '1, 32'h0, "unmapped");
      wb(1'b1, REG_CMD, 32'h2);
      rdchk(REG_STATUS, 32'hF, 32'h0, "status_early");
      slow <= 1'b1;
      setup(32'h8, 32'h020);
      rdchk(REG_STATUS, '1, 32'h00000303, "status_c1_16");
      chk("scale_off", 32'h0, 32'(scale_en_o));
      run_cycle(6, 64'hABCD55667788);
      slow <= 1'b0;
      setup(32'h0, 32'h112);
      rdchk(REG_STATUS, 32'hF, 32'h5, "status_mixed");
      setup(32'h0, 32'hC03);
      rdchk(REG_STATUS, 32'hF, 32'h5, "status_twelve");
      chk("exch_err", 32'h0, 32'(exch_o));
      position_i <= 32'h00000100;
      setup(32'h1, 32'h001);
      rdchk(REG_STATUS, '1, 32'h10000203, "status_c1_32");
      run_cycle(4, 64'h000185A0);
      setup(32'hA, 32'h002);
      rdchk(REG_STATUS, '1, 32'h00010103, "status_c2_16");
      chk("scale_en", 32'h1, 32'(scale_en_o));
      u_far.send_word(32'h00008055);
      wait_preset(32'h00000055);
      setup(32'h2, 32'h103);
      rdchk(REG_STATUS, '1, 32'h00020403, "status_c2_32");
      run_cycle(8, 64'h0000010000005566);
      wb(1'b1, REG_IRQ_STAT, 32'h1F);
      wb(1'b1, REG_IRQ_MASK, 32'h8);
      u_far.send_word(32'h80000123);
      wait_preset(32'h00000123);
      @(negedge clk_i);
      chk("irq_set", 32'h1, 32'(irq_o));
      rdchk(REG_IRQ_STAT, 32'h8, 32'h8, "irq_stat");
      wb(1'b1, REG_IRQ_STAT, 32'h8);
      @(negedge clk_i);
      chk("irq_clear", 32'h0, 32'(irq_o));
      wb(1'b1, REG_PRESET, 32'h00000777);
      setup(32'h2, 32'h004);
      @(posedge clk_i);
      ext_preset_i <= 1'b1;
      @(posedge clk_i);
      ext_preset_i <= 1'b0;
      wait_preset(32'h00000777);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end
endmodule : ecm_map_tb
